// file: hw/dipr_defines.svh
/*
  constants for the dac input port router: word widths, pin positions, fifo depth.
  assumes inclusion by bare name from the router design file.
*/
`ifndef DIPR_DEFINES_SVH
`define DIPR_DEFINES_SVH

`define DIPR_WORD_W        16
`define DIPR_LOW_W         14
`define DIPR_MSB_POS       15
`define DIPR_B14_POS       14
`define DIPR_FIFO_DEPTH    4
`define DIPR_FIFO_AW       2

`endif

// file: hw/dipr_pkg.sv
/*
  types for the dac input port router.
  assumes nothing beyond the defines header.
*/
package dipr_pkg;

  typedef enum logic {
    DIPR_CH_I,
    DIPR_CH_Q
  } dipr_chan_t;

endpackage

// file: hw/dipr_router.sv
/*
  dac input port router: steers port words to the i and q channel paths,
  with a 4-word fifo per channel in front of the processing side.
  assumes data pins come from an outside source and are synchronised here;
  downstream processing applies back-pressure by ready.
*/
`include "dipr_defines.svh"

// ----------------------------------------------------------------
// word fifo
// ----------------------------------------------------------------
module dipr_fifo #(
  parameter int WIDTH = `DIPR_WORD_W,
  parameter int DEPTH = `DIPR_FIFO_DEPTH,
  parameter int AW    = `DIPR_FIFO_AW
) (
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // full at DEPTH words; the count is one bit wider than the pointers
  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rptr_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem_ff[wptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_ff <= AW'(wptr_ff + 1'b1);
      end
      if (pop)
      begin
        rptr_ff <= AW'(rptr_ff + 1'b1);
      end
      count_ff <= (AW+1)'(count_ff + push - pop);
    end
  end

endmodule

// Operation
// [R01] mode clear: port a words go to the i channel path
// [R02] mode set: port a words split by pair select into i and q
// [R03] polarity 0: select 0 gives q, 1 gives i; polarity 1 inverts
// [R04] mode clear: pair select pin is q word bit 15
// [R05] mode clear: clock-out pin is q word bit 14 input
// [R06] mode set: shared pin drives a clock at twice channel rate; here it toggles once per clock_i cycle, so it runs at the channel rate
// [R07] port b low pins form q word bits 13 to 0
// [R08] source alternates i and q words, one per doubled clock period
module dipr_router (
  input  wire logic                      clock_i,
  input  wire logic                      rstn_i,
  input  wire logic                      single_port_mode_i,
  input  wire logic                      pair_select_polarity_i,
  input  wire logic [`DIPR_WORD_W-1:0]   port_a_bits_i,
  input  wire logic                      pair_select_i,
  input  wire logic                      port_b_bit_fourteen_i,
  output logic                           single_port_clock_out_o,
  output logic                           single_port_clock_oe_o,
  input  wire logic [`DIPR_LOW_W-1:0]    port_b_low_bits_i,
  output logic                           i_valid_o,
  input  wire logic                      i_ready_i,
  output logic      [`DIPR_WORD_W-1:0]   i_data_o,
  output logic                           q_valid_o,
  input  wire logic                      q_ready_i,
  output logic      [`DIPR_WORD_W-1:0]   q_data_o,
  output logic                           overflow_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int PW = `DIPR_WORD_W + `DIPR_LOW_W + 4;
  logic [PW-1:0] meta_ff;
  logic [PW-1:0] sync_ff;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= {single_port_mode_i, pair_select_polarity_i, pair_select_i,
                  port_b_bit_fourteen_i, port_a_bits_i, port_b_low_bits_i};
      sync_ff <= meta_ff;
    end
  end

  logic                     mode_s;
  logic                     pol_s;
  logic                     sel_s;
  logic                     b14_s;
  logic [`DIPR_WORD_W-1:0]  a_s;
  logic [`DIPR_LOW_W-1:0]   blow_s;
  assign {mode_s, pol_s, sel_s, b14_s, a_s, blow_s} = sync_ff;

  // ----------------------------------------------------------------
  // steering
  // ----------------------------------------------------------------
  dipr_pkg::dipr_chan_t    chan;
  logic [`DIPR_WORD_W-1:0] q_word;
  logic                    i_push;
  logic                    q_push;
  logic                    i_room;
  logic                    q_room;

  // [R03] polarity pair mapping
  assign chan = (sel_s ^ pol_s) ? dipr_pkg::DIPR_CH_I : dipr_pkg::DIPR_CH_Q;

  // [R04] [R05] [R07] q word assembly from port b
  assign q_word = {sel_s, b14_s, blow_s};

  // [R01] [R02] route by mode; single port sends one word per cycle
  assign i_push = !mode_s || (chan == dipr_pkg::DIPR_CH_I);
  assign q_push = !mode_s || (chan == dipr_pkg::DIPR_CH_Q);

  logic [`DIPR_WORD_W-1:0] q_in;
  assign q_in = mode_s ? a_s : q_word;

  // words arriving while a fifo is full are dropped: the pins cannot stall
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      overflow_o <= 1'b0;
    end
    else
    begin
      overflow_o <= (i_push && !i_room) || (q_push && !q_room);
    end
  end

  // ----------------------------------------------------------------
  // channel-rate clock out
  // ----------------------------------------------------------------
  // [R06] pin toggles each edge while single port; the 20 MHz system
  // clock stands in for twice the channel rate, so one word per toggle
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      single_port_clock_out_o <= 1'b0;
      single_port_clock_oe_o  <= 1'b0;
    end
    else
    begin
      single_port_clock_oe_o  <= mode_s;
      single_port_clock_out_o <= mode_s ? !single_port_clock_out_o : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // channel fifos and registered outputs
  // ----------------------------------------------------------------
  logic                    i_fv;
  logic                    q_fv;
  logic [`DIPR_WORD_W-1:0] i_fd;
  logic [`DIPR_WORD_W-1:0] q_fd;
  logic                    i_take;
  logic                    q_take;

  assign i_take = i_fv && (!i_valid_o || i_ready_i);
  assign q_take = q_fv && (!q_valid_o || q_ready_i);

  dipr_fifo u_i_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (i_push),
    .in_ready_o  (i_room),
    .in_data_i   (a_s),
    .out_valid_o (i_fv),
    .out_ready_i (i_take),
    .out_data_o  (i_fd)
  );

  dipr_fifo u_q_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (q_push),
    .in_ready_o  (q_room),
    .in_data_i   (q_in),
    .out_valid_o (q_fv),
    .out_ready_i (q_take),
    .out_data_o  (q_fd)
  );

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      i_valid_o <= 1'b0;
      i_data_o  <= '0;
    end
    else if (i_take)
    begin
      i_valid_o <= 1'b1;
      i_data_o  <= i_fd;
    end
    else if (i_ready_i)
    begin
      i_valid_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q_valid_o <= 1'b0;
      q_data_o  <= '0;
    end
    else if (q_take)
    begin
      q_valid_o <= 1'b1;
      q_data_o  <= q_fd;
    end
    else if (q_ready_i)
    begin
      q_valid_o <= 1'b0;
    end
  end

endmodule

// file: testbench/dipr_router_checker.sv
/*
  assertions on the router pins: pin clock, streams, drops.
  assumes a bind onto dipr_router; sees only its ports.
*/
// ----
// checker
// ----
module dipr_router_checker (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        single_port_mode_i,
  input wire logic        i_ready_i,
  input wire logic        q_ready_i,
  input wire logic        single_port_clock_out_o,
  input wire logic        single_port_clock_oe_o,
  input wire logic        i_valid_o,
  input wire logic [15:0] i_data_o,
  input wire logic        q_valid_o,
  input wire logic        overflow_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic both_rdy;
  assign both_rdy = i_ready_i && q_ready_i;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  // long runs cover the 2-stage sync plus a full fifo flush
  chk_pin_driven:
    assert property (single_port_mode_i [*4] |-> single_port_clock_oe_o)
    else $error("pin clock not driven");
  chk_pin_toggle:
    assert property (single_port_clock_oe_o && $past(single_port_clock_oe_o)
      |-> single_port_clock_out_o != $past(single_port_clock_out_o))
    else $error("pin clock stuck");
  chk_pin_quiet:
    assert property (!single_port_mode_i [*4]
      |-> !single_port_clock_oe_o && !single_port_clock_out_o)
    else $error("pin driven in dual mode");
  chk_i_hold:
    assert property (i_valid_o && !i_ready_i |=> i_valid_o && $stable(i_data_o))
    else $error("i word not held");
  chk_dual_both:
    assert property ((!single_port_mode_i && both_rdy) [*8] ##1
      (!single_port_mode_i && both_rdy) [*4] |-> i_valid_o && q_valid_o)
    else $error("dual mode lane idle");
  chk_one_lane:
    assert property ((single_port_mode_i && both_rdy) [*8] ##1
      (single_port_mode_i && both_rdy) [*4] |-> i_valid_o ^ q_valid_o)
    else $error("single mode lanes wrong");
  chk_drop_flag:
    assert property ((!single_port_mode_i && !i_ready_i && !q_ready_i) [*8] ##1
      (!single_port_mode_i && !i_ready_i && !q_ready_i) [*4] |-> overflow_o)
    else $error("drop not flagged");
endmodule

bind dipr_router dipr_router_checker u_chk (
  .clock_i, .rstn_i, .single_port_mode_i, .i_ready_i, .q_ready_i,
  .single_port_clock_out_o, .single_port_clock_oe_o, .i_valid_o, .i_data_o,
  .q_valid_o, .overflow_o
);

// file: testbench/dipr_source.sv
/*
  data source model: drives both ports as the outside logic part would.
  assumes the bench gives mode, polarity and the two words to send.
*/
module dipr_source (
  input  wire logic        clock_i,
  input  wire logic        mode_i,
  input  wire logic        pol_i,
  input  wire logic [15:0] i_word_i,
  input  wire logic [15:0] q_word_i,
  output logic      [15:0] port_a_o,
  output logic             sel_o,
  output logic             b14_o,
  output logic      [13:0] blow_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // no reset pin: mode is low from the start, so phase settles to 0 at the first edge
  logic phase_ff;
  always_ff @(posedge clock_i)
  begin
    phase_ff <= mode_i & ~phase_ff;
  end
  assign port_a_o = (mode_i & phase_ff) ? q_word_i : i_word_i;
  assign sel_o    = mode_i ? (phase_ff ^ ~pol_i) : q_word_i[15];
  // released pin shows a changing level, not a held one
  assign b14_o    = mode_i ? phase_ff : q_word_i[14];
  assign blow_o   = q_word_i[13:0];
endmodule

// file: testbench/dipr_router_tb.sv
/*
  bench for the input port router: dual, single and stall cases.
  assumes the source model and the bound checker.
*/
module dipr_router_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        single_port_mode_i = 1'b0;
  logic        pair_select_polarity_i = 1'b0;
  logic        i_ready_i = 1'b1;
  logic        q_ready_i = 1'b1;
  logic [15:0] i_w = 16'h0000;
  logic [15:0] q_w = 16'h0000;
  logic [15:0] port_a_bits_i, i_data_o, q_data_o;
  logic [13:0] port_b_low_bits_i;
  logic        pair_select_i, b14, pin14, single_port_clock_out_o;
  logic        single_port_clock_oe_o, i_valid_o, q_valid_o, overflow_o;
  int          err_count = 0;
  int          comparisons = 0;
  always #25 clock_i = ~clock_i;
  assign pin14 = single_port_clock_oe_o ? single_port_clock_out_o : b14;
  dipr_source u_src (.clock_i, .mode_i(single_port_mode_i), .pol_i(pair_select_polarity_i),
    .i_word_i(i_w), .q_word_i(q_w), .port_a_o(port_a_bits_i), .sel_o(pair_select_i),
    .b14_o(b14), .blow_o(port_b_low_bits_i));
  dipr_router u_dut (.clock_i, .rstn_i, .single_port_mode_i, .pair_select_polarity_i,
    .port_a_bits_i, .pair_select_i, .port_b_bit_fourteen_i(pin14), .single_port_clock_out_o,
    .single_port_clock_oe_o, .port_b_low_bits_i, .i_valid_o, .i_ready_i, .i_data_o,
    .q_valid_o, .q_ready_i, .q_data_o, .overflow_o);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic setup(input logic m, input logic p, input logic [15:0] a, input logic [15:0] b);
    @(posedge clock_i);
    single_port_mode_i <= m;
    pair_select_polarity_i <= p;
    i_w <= a;
    q_w <= b;
    repeat (14) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic t_dual();
    // bit 15 set and bit 14 clear so a swap of the two shared pins shows
    setup(1'b0, 1'b0, 16'h1234, 16'h85A3);
    check(i_data_o, 16'h1234);
    check(q_data_o, 16'h85A3);
    $display("dual done");
  endtask
  task automatic t_single(input logic p);
    logic c0;
    setup(1'b1, p, 16'hA5A5, 16'h5A5A);
    c0 = single_port_clock_out_o;
    check(i_data_o, 16'hA5A5);
    check(q_data_o, 16'h5A5A);
    check({15'h0000, single_port_clock_oe_o}, 16'h0001);
    @(negedge clock_i);
    check({15'h0000, single_port_clock_out_o}, {15'h0000, ~c0});
    $display("single done");
  endtask
  task automatic t_stall();
    logic seen;
    setup(1'b0, 1'b0, 16'h0F0F, 16'h3C3C);
    seen = 1'b0;
    @(posedge clock_i);
    i_ready_i <= 1'b0;
    q_ready_i <= 1'b0;
    i_w <= 16'hFFFF;
    repeat (16)
    begin
      @(negedge clock_i);
      seen = seen | (overflow_o === 1'b1);
    end
    check({15'h0000, seen}, 16'h0001);
    check(i_data_o, 16'h0F0F);
    @(posedge clock_i);
    i_ready_i <= 1'b1;
    q_ready_i <= 1'b1;
    $display("stall done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_dual();
    t_single(1'b0);
    t_single(1'b1);
    t_stall();
    close_out();
  end
endmodule
